// ===== hdl/bit_branch_exec.v
// Execution unit for bit-manipulation and relative branch instructions
//Behaviour
//- 0x8B, 3 bytes, 4 cycles: carry AND memory bit, or AND its inverse.
//- 0x0C dp 2B/4c, 0x1C abs 3B/5c: Z=A&M zero, N=M7, V=M6.
//- x1 sets, y1 clears a direct-page bit; 2 bytes, 4 cycles.
//- 0x0B sets, 0x2B clears an accumulator bit; 2 bytes, 2 cycles, flags kept.
//- 0x20 clears carry, 0xA0 sets carry; one byte, 2 cycles.
//- 0x40 clears page flag, 0xC0 sets it; one byte, 2 cycles.
//- 0x80 clears overflow plus a second flag; one byte, 2 cycles.
//- 0xAB, 3 bytes, 5 cycles: carry XOR memory bit or its inverse.
//- 0xCB, 3 bytes, 4 cycles: carry loaded from memory bit or its inverse.
//- 0x4B, 3 bytes, 5 cycles: invert memory bit in place, flags kept.
//- 0x6B, 3 bytes, 5 cycles: carry OR memory bit or its inverse.
//- 0xEB, 3 bytes, 6 cycles: carry written into memory bit.
//- 0x5C, 3 bytes, 6 cycles: N,Z from A-M; clear A's bits in M.
//- 0x3C, 3 bytes, 6 cycles: N,Z from A-M; set A's bits in M.
//- Branch on bit: acc 2B 4/6c, dp 3B 5/7c; y on clear, x on set.
//- 0x50 branches on carry zero, 0xD0 on carry one; 2 bytes, 2/4 cycles.
//- 0xF0 branches on zero one, 0x70 on zero zero; 2 bytes, 2/4 cycles.
//- 0x90 branches on negative one, 0x10 on negative zero; 2 bytes, 2/4.
//- 0x30 branches when overflow is zero; 2 bytes, 2/4 cycles.
//- 0x2F always branches; 2 bytes, always 4 cycles.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bit_branch_defs.vh"

module bit_branch_exec (
  // Clock, reset and clock enable
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        ce_i,
  // Register port
  input  wire [2:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  // Shared program and data memory port
  output reg  [15:0] mem_addr_o,
  output reg         mem_rd_o,
  output reg         mem_wr_o,
  output reg  [7:0]  mem_wdata_o,
  input  wire [7:0]  mem_rdata_i,
  // Instruction retire pulse
  output reg         retire_o
);

  // Sequencer states
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_OPC  = 3'd1;
  localparam [2:0] S_B1   = 3'd2;
  localparam [2:0] S_B2   = 3'd3;
  localparam [2:0] S_DATA = 3'd4;
  localparam [2:0] S_EXEC = 3'd5;
  localparam [2:0] S_WAIT = 3'd6;

  // Decode: {legal, length, cycles not taken, cycles taken, needs data byte}
  function [9:0] dec_info;
    input [7:0] op;
    begin
      dec_info = 10'h000;
      if (op[3:0] == `NIB_MEM_BIT) begin
        dec_info = {1'b1, 2'd2, 3'd4, 3'd4, 1'b1};
      end else if (op[3:0] == `NIB_ACC_BR) begin
        dec_info = {1'b1, 2'd2, 3'd4, 3'd6, 1'b0};
      end else if (op[3:0] == `NIB_DP_BR) begin
        dec_info = {1'b1, 2'd3, 3'd5, 3'd7, 1'b1};
      end else if (op == `OP_CARRY_AND || op == `OP_LOAD_CARRY) begin
        dec_info = {1'b1, 2'd3, 3'd4, 3'd4, 1'b1};
      end else if (op == `OP_CARRY_XOR || op == `OP_CARRY_OR || op == `OP_INVERT_BIT) begin
        dec_info = {1'b1, 2'd3, 3'd5, 3'd5, 1'b1};
      end else if (op == `OP_STORE_CARRY || op == `OP_TEST_CLEAR || op == `OP_TEST_SET) begin
        dec_info = {1'b1, 2'd3, 3'd6, 3'd6, 1'b1};
      end else if (op == `OP_BIT_TEST_DP) begin
        dec_info = {1'b1, 2'd2, 3'd4, 3'd4, 1'b1};
      end else if (op == `OP_BIT_TEST_ABS) begin
        dec_info = {1'b1, 2'd3, 3'd5, 3'd5, 1'b1};
      end else if (op == `OP_ACC_BIT_HIGH || op == `OP_ACC_BIT_CLEAR) begin
        dec_info = {1'b1, 2'd2, 3'd2, 3'd2, 1'b0};
      end else if (op == `OP_CARRY_CLEAR || op == `OP_CARRY_HIGH || op == `OP_PAGE_CLEAR ||
                   op == `OP_PAGE_HIGH || op == `OP_OVERFLOW_CLEAR) begin
        dec_info = {1'b1, 2'd1, 3'd2, 3'd2, 1'b0};
      end else if (op == `OP_BR_CARRY_LOW || op == `OP_BR_CARRY_HIGH || op == `OP_BR_ZERO_HIGH ||
                   op == `OP_BR_ZERO_LOW || op == `OP_BR_NEG_HIGH || op == `OP_BR_NEG_LOW ||
                   op == `OP_BR_OVF_LOW) begin
        dec_info = {1'b1, 2'd2, 3'd2, 3'd4, 1'b0};
      end else if (op == `OP_BR_ALWAYS) begin
        dec_info = {1'b1, 2'd2, 3'd4, 3'd4, 1'b0};
      end
    end
  endfunction

  // Memory-bit operand forms share one address layout
  function is_membit;
    input [7:0] op;
    begin
      is_membit = (op == `OP_CARRY_AND) || (op == `OP_CARRY_XOR) || (op == `OP_CARRY_OR) ||
                  (op == `OP_LOAD_CARRY) || (op == `OP_INVERT_BIT) || (op == `OP_STORE_CARRY);
    end
  endfunction

  // Machine cycles to core clocks
  function [3:0] to_clocks;
    input [2:0] cyc;
    begin
      to_clocks = {1'b0, cyc} * `CLKS_PER_MCYC;
    end
  endfunction

  // Architectural and sequencer state
  reg [2:0]  state_q;
  reg [3:0]  cnt_q;
  reg [7:0]  opc_q;
  reg [7:0]  op1_q;
  reg [7:0]  op2_q;
  reg [7:0]  data_q;
  reg [15:0] daddr_q;
  reg [7:0]  acc_q;
  reg [7:0]  psw_q;
  reg [15:0] pc_q;
  reg        run_q;
  reg        illegal_q;

  // Combinational execute results
  reg [9:0]  info_w;
  reg [2:0]  bitn;
  reg        mbit;
  reg        mbit_eff;
  reg [7:0]  rel;
  reg        take;
  reg [7:0]  diff;
  reg [7:0]  mask;

  always @* begin
    info_w   = dec_info(opc_q);
    mbit_eff = 1'b0;
    mbit     = 1'b0;
    take     = 1'b0;
    diff     = acc_q - data_q;
    rel      = op1_q;
    // Bit number: memory-bit forms in the operand, families in the opcode
    if (is_membit(opc_q)) begin
      bitn = op2_q[7:5];
    end else if (opc_q == `OP_ACC_BIT_HIGH || opc_q == `OP_ACC_BIT_CLEAR) begin
      bitn = op1_q[2:0];
    end else begin
      bitn = opc_q[7:5];
    end
    mask = 8'h01 << bitn;
    mbit = data_q[bitn];
    mbit_eff = mbit ^ op2_q[4];
    // Branch condition; the x forms have opcode bit 4 low
    if (opc_q[3:0] == `NIB_ACC_BR) begin
      take = acc_q[bitn] ^ opc_q[4];
    end else if (opc_q[3:0] == `NIB_DP_BR) begin
      take = mbit ^ opc_q[4];
      rel  = op2_q;
    end else if (opc_q == `OP_BR_CARRY_LOW) begin
      take = ~psw_q[`FLAG_C];
    end else if (opc_q == `OP_BR_CARRY_HIGH) begin
      take = psw_q[`FLAG_C];
    end else if (opc_q == `OP_BR_ZERO_HIGH) begin
      take = psw_q[`FLAG_Z];
    end else if (opc_q == `OP_BR_ZERO_LOW) begin
      take = ~psw_q[`FLAG_Z];
    end else if (opc_q == `OP_BR_NEG_HIGH) begin
      take = psw_q[`FLAG_N];
    end else if (opc_q == `OP_BR_NEG_LOW) begin
      take = ~psw_q[`FLAG_N];
    end else if (opc_q == `OP_BR_OVF_LOW) begin
      take = ~psw_q[`FLAG_V];
    end else if (opc_q == `OP_BR_ALWAYS) begin
      take = 1'b1;
    end
  end

  // Clock target of the running instruction, picked by branch outcome
  wire [3:0] tgt_w = take ? to_clocks(info_w[3:1]) : to_clocks(info_w[6:4]);
  reg  [3:0] tgt_q;
  // Decode of the byte on the memory bus, used while the opcode is fetched
  wire [9:0] fetch_info_w = dec_info(mem_rdata_i);

  // Sequencer, register port writes and architectural state in one process
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q     <= S_IDLE;
      cnt_q       <= 4'h0;
      tgt_q       <= 4'h0;
      opc_q       <= 8'h00;
      op1_q       <= 8'h00;
      op2_q       <= 8'h00;
      data_q      <= 8'h00;
      daddr_q     <= 16'h0000;
      acc_q       <= `ACC_RST;
      psw_q       <= `PSW_RST;
      pc_q        <= `PC_RST;
      run_q       <= 1'b0;
      illegal_q   <= 1'b0;
      mem_addr_o  <= 16'h0000;
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= 8'h00;
      retire_o    <= 1'b0;
    end else if (ce_i) begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      retire_o <= 1'b0;
      cnt_q    <= cnt_q + 4'h1;
      // Software side; architectural writes only while stopped, so the core never races them
      if (reg_wr_i) begin
        if (reg_addr_i == `REG_CTRL) begin
          run_q <= reg_wdata_i[`CTRL_RUN_BIT];
        end else if (reg_addr_i == `REG_STATUS) begin
          if (reg_wdata_i[`STAT_ILLEGAL_BIT]) begin
            illegal_q <= 1'b0;
          end
        end else if (!run_q && state_q == S_IDLE) begin
          if (reg_addr_i == `REG_ACC) begin
            acc_q <= reg_wdata_i;
          end else if (reg_addr_i == `REG_PSW) begin
            psw_q <= reg_wdata_i;
          end else if (reg_addr_i == `REG_PCL) begin
            pc_q[7:0] <= reg_wdata_i;
          end else if (reg_addr_i == `REG_PCH) begin
            pc_q[15:8] <= reg_wdata_i;
          end
        end
      end
      case (state_q)
        S_IDLE: begin
          // Opcode fetch opens the instruction at clock 0
          if (run_q) begin
            mem_addr_o <= pc_q;
            mem_rd_o   <= 1'b1;
            pc_q       <= pc_q + 16'h0001;
            cnt_q      <= 4'h0;
            state_q    <= S_OPC;
          end
        end
        S_OPC: begin
          opc_q <= mem_rdata_i;
          if (!fetch_info_w[9]) begin
            // Unknown opcode: stop the core; placed after the write above so it wins
            illegal_q <= 1'b1;
            run_q     <= 1'b0;
            state_q   <= S_IDLE;
          end else if (fetch_info_w[8:7] != 2'd1) begin
            mem_addr_o <= pc_q;
            mem_rd_o   <= 1'b1;
            pc_q       <= pc_q + 16'h0001;
            state_q    <= S_B1;
          end else begin
            state_q <= S_EXEC;
          end
        end
        S_B1: begin
          op1_q <= mem_rdata_i;
          if (info_w[8:7] == 2'd3) begin
            mem_addr_o <= pc_q;
            mem_rd_o   <= 1'b1;
            pc_q       <= pc_q + 16'h0001;
            state_q    <= S_B2;
          end else if (info_w[0]) begin
            // Direct page sits in page 0 or 1 as the page flag selects
            daddr_q    <= {7'h00, psw_q[`FLAG_G], mem_rdata_i};
            mem_addr_o <= {7'h00, psw_q[`FLAG_G], mem_rdata_i};
            mem_rd_o   <= 1'b1;
            state_q    <= S_DATA;
          end else begin
            state_q <= S_EXEC;
          end
        end
        S_B2: begin
          // Every three-byte form reads a data byte
          op2_q    <= mem_rdata_i;
          mem_rd_o <= 1'b1;
          state_q  <= S_DATA;
          if (is_membit(opc_q)) begin
            daddr_q    <= {4'h0, mem_rdata_i[3:0], op1_q};
            mem_addr_o <= {4'h0, mem_rdata_i[3:0], op1_q};
          end else if (opc_q[3:0] == `NIB_DP_BR) begin
            daddr_q    <= {7'h00, psw_q[`FLAG_G], op1_q};
            mem_addr_o <= {7'h00, psw_q[`FLAG_G], op1_q};
          end else begin
            daddr_q    <= {mem_rdata_i, op1_q};
            mem_addr_o <= {mem_rdata_i, op1_q};
          end
        end
        S_DATA: begin
          data_q  <= mem_rdata_i;
          state_q <= S_EXEC;
        end
        S_EXEC: begin
          tgt_q      <= tgt_w;
          mem_addr_o <= daddr_q;
          if (opc_q == `OP_CARRY_AND) begin
            psw_q[`FLAG_C] <= psw_q[`FLAG_C] & mbit_eff;
          end else if (opc_q == `OP_CARRY_XOR) begin
            psw_q[`FLAG_C] <= psw_q[`FLAG_C] ^ mbit_eff;
          end else if (opc_q == `OP_CARRY_OR) begin
            psw_q[`FLAG_C] <= psw_q[`FLAG_C] | mbit_eff;
          end else if (opc_q == `OP_LOAD_CARRY) begin
            psw_q[`FLAG_C] <= mbit_eff;
          end else if (opc_q == `OP_INVERT_BIT) begin
            mem_wdata_o <= data_q ^ mask;
            mem_wr_o    <= 1'b1;
          end else if (opc_q == `OP_STORE_CARRY) begin
            mem_wdata_o <= psw_q[`FLAG_C] ? (data_q | mask) : (data_q & ~mask);
            mem_wr_o    <= 1'b1;
          end else if (opc_q == `OP_BIT_TEST_DP || opc_q == `OP_BIT_TEST_ABS) begin
            psw_q[`FLAG_Z] <= (acc_q & data_q) == 8'h00;
            psw_q[`FLAG_N] <= data_q[7];
            psw_q[`FLAG_V] <= data_q[6];
          end else if (opc_q == `OP_TEST_CLEAR || opc_q == `OP_TEST_SET) begin
            psw_q[`FLAG_N] <= diff[7];
            psw_q[`FLAG_Z] <= diff == 8'h00;
            mem_wdata_o    <= (opc_q == `OP_TEST_SET) ? (data_q | acc_q) : (data_q & ~acc_q);
            mem_wr_o       <= 1'b1;
          end else if (opc_q[3:0] == `NIB_MEM_BIT) begin
            mem_wdata_o <= opc_q[4] ? (data_q & ~mask) : (data_q | mask);
            mem_wr_o    <= 1'b1;
          end else if (opc_q == `OP_ACC_BIT_HIGH) begin
            acc_q <= acc_q | mask;
          end else if (opc_q == `OP_ACC_BIT_CLEAR) begin
            acc_q <= acc_q & ~mask;
          end else if (opc_q == `OP_CARRY_CLEAR || opc_q == `OP_CARRY_HIGH) begin
            psw_q[`FLAG_C] <= opc_q[7];
          end else if (opc_q == `OP_PAGE_CLEAR || opc_q == `OP_PAGE_HIGH) begin
            psw_q[`FLAG_G] <= opc_q[7];
          end else if (opc_q == `OP_OVERFLOW_CLEAR) begin
            psw_q[`FLAG_V] <= 1'b0;
            psw_q[`FLAG_H] <= 1'b0;
          end
          // Offset is signed and counts from the byte after the instruction
          if (take) begin
            pc_q <= pc_q + {{8{rel[7]}}, rel};
          end
          // Retire is registered and the count trails the fetch by one, so stop two short
          if (cnt_q >= tgt_w - 4'h2) begin
            retire_o <= 1'b1;
            state_q  <= S_IDLE;
          end else begin
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Pads out to the documented cycle count
          if (cnt_q >= tgt_q - 4'h2) begin
            retire_o <= 1'b1;
            state_q  <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Read data for the cycle after a read strobe, zero otherwise
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        if (reg_addr_i == `REG_CTRL) begin
          reg_rdata_o <= {7'h00, run_q};
        end else if (reg_addr_i == `REG_STATUS) begin
          reg_rdata_o <= {6'h00, illegal_q, state_q != S_IDLE};
        end else if (reg_addr_i == `REG_ACC) begin
          reg_rdata_o <= acc_q;
        end else if (reg_addr_i == `REG_PSW) begin
          reg_rdata_o <= psw_q;
        end else if (reg_addr_i == `REG_PCL) begin
          reg_rdata_o <= pc_q[7:0];
        end else if (reg_addr_i == `REG_PCH) begin
          reg_rdata_o <= pc_q[15:8];
        end else if (reg_addr_i == `REG_LAST_OPC) begin
          reg_rdata_o <= opc_q;
        end
      end
    end
  end

endmodule // bit_branch_exec
`default_nettype wire

// ===== hdl/bit_branch_defs.vh
// Constants for the bit-manipulation and branch execution unit
`ifndef BIT_BRANCH_DEFS_VH
`define BIT_BRANCH_DEFS_VH

// Register indices on the plain register port
`define REG_CTRL      3'h0
`define REG_STATUS    3'h1
`define REG_ACC       3'h2
`define REG_PSW       3'h3
`define REG_PCL       3'h4
`define REG_PCH       3'h5
`define REG_LAST_OPC  3'h6

// Field positions
`define CTRL_RUN_BIT     0
`define STAT_BUSY_BIT    0
`define STAT_ILLEGAL_BIT 1
`define FLAG_N 7
`define FLAG_V 6
`define FLAG_G 5
`define FLAG_B 4
`define FLAG_H 3
`define FLAG_I 2
`define FLAG_Z 1
`define FLAG_C 0

// Reset values
`define ACC_RST 8'h00
`define PSW_RST 8'h00
`define PC_RST  16'h0000

// Timing: core clocks per documented machine cycle
`define CLKS_PER_MCYC 4'h2

// Fixed opcodes
`define OP_CARRY_AND      8'h8B
`define OP_CARRY_XOR      8'hAB
`define OP_CARRY_OR       8'h6B
`define OP_LOAD_CARRY     8'hCB
`define OP_INVERT_BIT     8'h4B
`define OP_STORE_CARRY    8'hEB
`define OP_BIT_TEST_DP    8'h0C
`define OP_BIT_TEST_ABS   8'h1C
`define OP_TEST_CLEAR     8'h5C
`define OP_TEST_SET       8'h3C
`define OP_ACC_BIT_HIGH   8'h0B
`define OP_ACC_BIT_CLEAR  8'h2B
`define OP_CARRY_CLEAR    8'h20
`define OP_CARRY_HIGH     8'hA0
`define OP_PAGE_CLEAR     8'h40
`define OP_PAGE_HIGH      8'hC0
`define OP_OVERFLOW_CLEAR 8'h80
`define OP_BR_CARRY_LOW   8'h50
`define OP_BR_CARRY_HIGH  8'hD0
`define OP_BR_ZERO_HIGH   8'hF0
`define OP_BR_ZERO_LOW    8'h70
`define OP_BR_NEG_HIGH    8'h90
`define OP_BR_NEG_LOW     8'h10
`define OP_BR_OVF_LOW     8'h30
`define OP_BR_ALWAYS      8'h2F

// Low nibbles of the bit-numbered families
`define NIB_MEM_BIT  4'h1
`define NIB_ACC_BR   4'h2
`define NIB_DP_BR    4'h3

`endif

// ===== verification/bit_branch_exec_sva.sv
// Port-level assertions for the bit and branch execution unit
`timescale 1ns/1ps
`default_nettype none
`include "bit_branch_defs.vh"

module bit_branch_exec_sva (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       nrst_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic       reg_wr_i,
  // Memory port and retire
  input wire logic       mem_rd_o,
  input wire logic       mem_wr_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic       retire_o
);
  logic       want_q;
  logic       wrote_q;
  logic [4:0] cnt_q;
  logic [7:0] opc_q;

  // Follow each opcode fetch; a new fetch is due after retire or a control write
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      want_q  <= 1'b1;
      wrote_q <= 1'b0;
      cnt_q   <= 5'h00;
      opc_q   <= 8'h00;
    end else begin
      if (mem_rd_o && want_q) begin
        // The opcode stands on the bus in the fetch cycle itself
        cnt_q   <= 5'h00;
        wrote_q <= 1'b0;
        opc_q   <= mem_rdata_i;
      end else begin
        cnt_q   <= cnt_q + 5'h01; // Wraps while idle, harmless as no retire follows
        wrote_q <= wrote_q | mem_wr_o;
      end
      if (retire_o || (reg_wr_i && reg_addr_i == `REG_CTRL)) begin
        want_q <= 1'b1;
      end else if (mem_rd_o) begin
        want_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Retire of one given opcode; the count then holds clocks since its fetch minus two
  sequence s_done(logic [7:0] op);
    retire_o && opc_q == op;
  endsequence
  sequence s_next_fetch;
    !retire_o && mem_rd_o;
  endsequence

  a_and_clocks: assert property (s_done(`OP_CARRY_AND) |-> cnt_q == 5'd6) else $error("and length");
  a_dp_test_len: assert property (s_done(`OP_BIT_TEST_DP) |-> cnt_q == 5'd6) else $error("test length");
  a_abs_test_len: assert property (s_done(`OP_BIT_TEST_ABS) |-> cnt_q == 5'd8) else $error("test length");
  a_xor_clocks: assert property (s_done(`OP_CARRY_XOR) |-> cnt_q == 5'd8) else $error("xor length");
  a_or_clocks: assert property (s_done(`OP_CARRY_OR) |-> cnt_q == 5'd8) else $error("or length");
  a_load_no_write: assert property (s_done(`OP_LOAD_CARRY) |-> cnt_q == 5'd6 && !wrote_q)
    else $error("load");
  a_invert_write: assert property (s_done(`OP_INVERT_BIT) |-> cnt_q == 5'd8 && wrote_q)
    else $error("invert");
  a_store_write: assert property (s_done(`OP_STORE_CARRY) |-> cnt_q == 5'd10 && wrote_q)
    else $error("store");
  a_tclr_write: assert property (s_done(`OP_TEST_CLEAR) |-> cnt_q == 5'd10 && wrote_q) else $error("tclr");
  a_tset_write: assert property (s_done(`OP_TEST_SET) |-> cnt_q == 5'd10 && wrote_q) else $error("tset");
  a_always_branch: assert property (s_done(`OP_BR_ALWAYS) |-> cnt_q == 5'd6) else $error("always branch");
  a_dp_bit_write: assert property (retire_o && opc_q[3:0] == `NIB_MEM_BIT |-> cnt_q == 5'd6 && wrote_q)
    else $error("dp bit op");
  a_short_ops: assert property (retire_o && opc_q inside
    {8'h0B, 8'h2B, 8'h20, 8'hA0, 8'h40, 8'hC0, 8'h80} |-> cnt_q == 5'd2) else $error("short op length");
  a_flag_branch: assert property (retire_o && opc_q inside
    {8'h50, 8'hD0, 8'hF0, 8'h70, 8'h90, 8'h10, 8'h30} |-> cnt_q == 5'd2 || cnt_q == 5'd6)
    else $error("flag branch length");
  a_acc_bit_branch: assert property (retire_o && opc_q[3:0] == `NIB_ACC_BR
    |-> cnt_q == 5'd6 || cnt_q == 5'd10) else $error("acc bit branch length");
  a_dp_bit_branch: assert property (retire_o && opc_q[3:0] == `NIB_DP_BR
    |-> cnt_q == 5'd8 || cnt_q == 5'd12) else $error("dp bit branch length");
  a_retire_fetch: assert property (retire_o |=> s_next_fetch) else $error("no fetch after retire");
endmodule // bit_branch_exec_sva

bind bit_branch_exec bit_branch_exec_sva i_bit_branch_exec_sva (
  .clk_i       (clk_i),
  .nrst_i      (nrst_i),
  .reg_addr_i  (reg_addr_i),
  .reg_wr_i    (reg_wr_i),
  .mem_rd_o    (mem_rd_o),
  .mem_wr_o    (mem_wr_o),
  .mem_rdata_i (mem_rdata_i),
  .retire_o    (retire_o)
);

`default_nettype wire

// ===== verification/bit_branch_exec_tb.sv
// Self-checking bench for the bit and branch execution unit
`timescale 1ns/1ps
`default_nettype none
`include "bit_branch_defs.vh"

module bit_branch_exec_tb;
  logic        clk_i;
  logic        nrst_i;
  logic        ce_i;
  logic [2:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic [15:0] mem_addr_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  mem_rdata_i;
  logic        retire_o;
  logic [7:0]  mem [0:65535];
  logic [7:0]  rv;
  int          bad_count;
  int          compares;

  // Clock enable is dropped once to show that a frozen core ignores writes
  bit_branch_exec i_bit_branch_exec (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i    (reg_wr_i),
    .reg_rd_i    (reg_rd_i),
    .reg_rdata_o (reg_rdata_o),
    .mem_addr_o  (mem_addr_o),
    .mem_rd_o    (mem_rd_o),
    .mem_wr_o    (mem_wr_o),
    .mem_wdata_o (mem_wdata_o),
    .mem_rdata_i (mem_rdata_i),
    .retire_o    (retire_o)
  );

  // 125 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Memory writes on the edge after the write pulse
  always @(posedge clk_i) begin
    if (mem_wr_o) begin
      mem[mem_addr_o] <= mem_wdata_o;
    end
  end

  // Read data stand in the strobe cycle, as the core takes them on the next edge;
  // otherwise the inverse, so stale data never matches
  assign mem_rdata_i = mem_rd_o ? mem[mem_addr_o] : ~mem[mem_addr_o];

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // Run one instruction at 0100h; an undecoded FFh at the next address stops the core
  task automatic ri(input logic [7:0] b0, b1, b2, acc, psw, dat, input int clks,
                    input logic [15:0] npc, input logic [7:0] eacc, epsw, edat);
    logic [15:0] da;
    logic [15:0] pe;
    int          t;
    int          tf;
    int          tr;
    da = (b0[3:0] == 4'h1 || b0[3:0] == 4'h3 || b0 == `OP_BIT_TEST_DP) ? 16'h0040 : 16'h0240;
    pe = npc + 16'h0001;
    mem[16'h0100] = b0;
    mem[16'h0101] = b1;
    mem[16'h0102] = b2;
    mem[da] = dat;
    mem[npc] = 8'hFF;
    wr(`REG_PCL, 8'h00);
    wr(`REG_PCH, 8'h01);
    wr(`REG_ACC, acc);
    wr(`REG_PSW, psw);
    wr(`REG_CTRL, 8'h01);
    tf = -1;
    tr = -1;
    for (t = 0; t < 40 && tr < 0; t++) begin
      @(posedge clk_i);
      #1;
      if (mem_rd_o && tf < 0) tf = t;
      if (retire_o) tr = t;
    end
    chk("clocks", tr - tf + 1, clks);
    rv = 8'h01;
    for (t = 0; t < 20 && rv[0] !== 1'b0; t++) rd(`REG_CTRL, rv);
    rd(`REG_STATUS, rv);
    chk("status", rv, 8'h02);
    rd(`REG_ACC, rv);
    chk("acc", rv, eacc);
    rd(`REG_PSW, rv);
    chk("psw", rv, epsw);
    rd(`REG_PCL, rv);
    chk("pcl", rv, pe[7:0]);
    rd(`REG_PCH, rv);
    chk("pch", rv, pe[15:8]);
    chk("memory", mem[da], edat);
    wr(`REG_STATUS, 8'h02);
  endtask

  task automatic complete_run;
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    bad_count = 0;
    compares = 0;
    nrst_i = 1'b0;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    ce_i = 1'b1;
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], rv);
      chk("reset value", rv, 8'h00);
    end
    // A write while the clock enable is low must leave the accumulator alone
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(`REG_ACC, 8'h5A);
    ce_i <= 1'b1;
    rd(`REG_ACC, rv);
    chk("frozen write", rv, 8'h00);
    ri(8'h8B,8'h40,8'h62,8'h00,8'h01,8'h08,8,16'h0103,8'h00,8'h01,8'h08);
    ri(8'h8B,8'h40,8'h72,8'h00,8'h01,8'h08,8,16'h0103,8'h00,8'h00,8'h08);
    ri(8'hAB,8'h40,8'h72,8'h00,8'h00,8'h00,10,16'h0103,8'h00,8'h01,8'h00);
    ri(8'hAB,8'h40,8'h62,8'h00,8'h01,8'h08,10,16'h0103,8'h00,8'h00,8'h08);
    ri(8'h6B,8'h40,8'h72,8'h00,8'h00,8'h00,10,16'h0103,8'h00,8'h01,8'h00);
    ri(8'hCB,8'h40,8'h72,8'h00,8'h01,8'h08,8,16'h0103,8'h00,8'h00,8'h08);
    ri(8'h4B,8'h40,8'h62,8'h00,8'hC3,8'h08,10,16'h0103,8'h00,8'hC3,8'h00);
    ri(8'hEB,8'h40,8'hE2,8'h00,8'h01,8'h00,12,16'h0103,8'h00,8'h01,8'h80);
    ri(8'h0C,8'h40,8'h00,8'h0F,8'h00,8'hC0,8,16'h0102,8'h0F,8'hC2,8'hC0);
    ri(8'h1C,8'h40,8'h02,8'h80,8'h43,8'h80,10,16'h0103,8'h80,8'h81,8'h80);
    ri(8'hE1,8'h40,8'h00,8'h00,8'h83,8'h00,8,16'h0102,8'h00,8'h83,8'h80);
    ri(8'h11,8'h40,8'h00,8'h00,8'h83,8'hFF,8,16'h0102,8'h00,8'h83,8'hFE);
    ri(8'h0B,8'h07,8'h00,8'h00,8'h83,8'h00,4,16'h0102,8'h80,8'h83,8'h00);
    ri(8'h2B,8'h00,8'h00,8'hFF,8'h83,8'h00,4,16'h0102,8'hFE,8'h83,8'h00);
    ri(8'h20,8'h00,8'h00,8'h00,8'hFF,8'h00,4,16'h0101,8'h00,8'hFE,8'h00);
    ri(8'hA0,8'h00,8'h00,8'h00,8'h00,8'h00,4,16'h0101,8'h00,8'h01,8'h00);
    ri(8'h40,8'h00,8'h00,8'h00,8'hFF,8'h00,4,16'h0101,8'h00,8'hDF,8'h00);
    ri(8'hC0,8'h00,8'h00,8'h00,8'h00,8'h00,4,16'h0101,8'h00,8'h20,8'h00);
    ri(8'h80,8'h00,8'h00,8'h00,8'hFF,8'h00,4,16'h0101,8'h00,8'hB7,8'h00);
    ri(8'h5C,8'h40,8'h02,8'h0F,8'h00,8'h3C,12,16'h0103,8'h0F,8'h80,8'h30);
    ri(8'h3C,8'h40,8'h02,8'h81,8'h02,8'h01,12,16'h0103,8'h81,8'h80,8'h81);
    ri(8'h50,8'h10,8'h00,8'h00,8'h00,8'h00,8,16'h0112,8'h00,8'h00,8'h00);
    ri(8'h50,8'h10,8'h00,8'h00,8'h01,8'h00,4,16'h0102,8'h00,8'h01,8'h00);
    ri(8'hD0,8'h80,8'h00,8'h00,8'h01,8'h00,8,16'h0082,8'h00,8'h01,8'h00);
    ri(8'hF0,8'h10,8'h00,8'h00,8'h02,8'h00,8,16'h0112,8'h00,8'h02,8'h00);
    ri(8'h70,8'h10,8'h00,8'h00,8'h02,8'h00,4,16'h0102,8'h00,8'h02,8'h00);
    ri(8'h90,8'h10,8'h00,8'h00,8'h80,8'h00,8,16'h0112,8'h00,8'h80,8'h00);
    ri(8'h10,8'h10,8'h00,8'h00,8'h80,8'h00,4,16'h0102,8'h00,8'h80,8'h00);
    ri(8'h30,8'h10,8'h00,8'h00,8'h00,8'h00,8,16'h0112,8'h00,8'h00,8'h00);
    ri(8'h30,8'h10,8'h00,8'h00,8'h40,8'h00,4,16'h0102,8'h00,8'h40,8'h00);
    ri(8'h2F,8'hF0,8'h00,8'h00,8'hFF,8'h00,8,16'h00F2,8'h00,8'hFF,8'h00);
    ri(8'hE2,8'h10,8'h00,8'h80,8'h00,8'h00,12,16'h0112,8'h80,8'h00,8'h00);
    ri(8'h12,8'h10,8'h00,8'h01,8'h00,8'h00,8,16'h0102,8'h01,8'h00,8'h00);
    ri(8'h73,8'h40,8'h10,8'h00,8'h00,8'h00,14,16'h0113,8'h00,8'h00,8'h00);
    ri(8'h63,8'h40,8'h10,8'h00,8'h00,8'h00,10,16'h0103,8'h00,8'h00,8'h00);
    complete_run;
  end

  // Watchdog: the tests need about 1200 cycles, so 20000 means a hang
  initial begin
    #160000;
    bad_count++;
    complete_run;
  end
endmodule // bit_branch_exec_tb

`default_nettype wire
